//--- conversion_start_bit_cfg.svh
// Constants for the converter sequencer: register map, fields, timing.
// Assumes inclusion by bare name from the design file.
`ifndef CONVERSION_START_BIT_CFG_SVH
`define CONVERSION_START_BIT_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define CONVERSION_START_BIT_OFF_CTRL   8'h00
`define CONVERSION_START_BIT_OFF_RESH   8'h04
`define CONVERSION_START_BIT_OFF_AUX    8'h08
`define CONVERSION_START_BIT_OFF_PINS   8'h0c

// ==========================================================
// Control and auxiliary register fields
`define CONVERSION_START_BIT_CTRL_RESLO 7:6
`define CONVERSION_START_BIT_CTRL_EXT   5
`define CONVERSION_START_BIT_CTRL_DONE  4
`define CONVERSION_START_BIT_CTRL_START 3
`define CONVERSION_START_BIT_CTRL_CHAN  2:0
`define CONVERSION_START_BIT_AUX_FAST   7
`define CONVERSION_START_BIT_AUX_IDLE   6

// ==========================================================
// Reset values
`define CONVERSION_START_BIT_RST_CHAN   3'h0
`define CONVERSION_START_BIT_RST_RES    10'h000
`define CONVERSION_START_BIT_RST_PRE    3'h0

// ==========================================================
// Timing in machine cycles, prescaler in oscillator periods; one machine cycle is six oscillator periods
`define CONVERSION_START_BIT_PRE_LAST   3'h5
`define CONVERSION_START_BIT_INIT_LAST  3'h1
`define CONVERSION_START_BIT_SAMP_LAST  3'h7
`define CONVERSION_START_BIT_FSAMP_LAST 3'h5
`define CONVERSION_START_BIT_BIT_LAST   3'h3
`define CONVERSION_START_BIT_FBIT_LAST  3'h1
`define CONVERSION_START_BIT_MC_10      6'h32
`define CONVERSION_START_BIT_MC_8       6'h18

// ==========================================================
// Successive approximation
`define CONVERSION_START_BIT_SAR_MSB    10'h200
`define CONVERSION_START_BIT_BITP_MSB   4'h9
`define CONVERSION_START_BIT_BITP_LSB10 4'h0
`define CONVERSION_START_BIT_BITP_LSB8  4'h2

`endif

//--- conversion_start_bit_pkg.sv
// Types shared by the converter sequencer.
// Assumes nothing of its surroundings.
package conversion_start_bit_pkg;

	// ==========================================================
	// Conversion phases, one-hot
	typedef enum logic [3:0] {
		CONVERSION_START_BIT_IDLE   = 4'h1,
		CONVERSION_START_BIT_INIT   = 4'h2,
		CONVERSION_START_BIT_SAMPLE = 4'h4,
		CONVERSION_START_BIT_CONV   = 4'h8
	} conversion_start_bit_state_t;

endpackage

//--- conversion_start_bit_seq.sv
// Successive-approximation converter sequencer with an APB register file.
// Assumes pclk is the oscillator, the comparator output and start pin are
// asynchronous, and the power-state inputs come from logic on pclk.
//
// Operation
// - Ten-bit conversion takes 50 machine cycles
// - Fast mode: 8 bits, 24 cycles, high register
// - Idle-activity bit keeps converter powered in idle
// - External enable off: software start only
// - External enable on: software or rising pin edge
// - Pin edge seen at cycle end, starts the cycle after next
// - Software start begins at next machine cycle
// - Start bit: command flop plus status flop
// - Two init cycles; status set after first
// - Eight machine cycles (six in fast mode) sample the selected input
// - Approximate from MSB, keep bit if above DAC
// - Four machine cycles per result bit (two in fast mode)
// - Done sets flag, high byte, two low bits
// - Done sets and status clears 50 cycles after command (24 in fast mode)
// - Three low control bits select the channel
// - Starts ignored while a conversion runs
// - Result held while done flag is set
// - Entering idle or power-down aborts conversion
// - Entering idle keeps a flagged result
// - Analog port input only, digitally readable
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "conversion_start_bit_cfg.svh"

module conversion_start_bit_seq (
	// APB slave
	input  logic                pclk,
	input  logic                presetn,
	input  logic                psel,
	input  logic                penable,
	input  logic                pwrite,
	input  logic [7:0]          paddr,
	input  logic [31:0]         pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	// Processor power state
	input  logic                idle_mode,
	input  logic                power_down,
	// Pins
	input  logic                external_start_pin,
	input  logic [7:0]          port5_pins,
	// Analog front end
	input  logic                cmp_above,
	output logic [9:0]          internal_dac_voltage,
	output logic [2:0]          channel_select,
	output logic                sample_en,
	output logic                converter_power,
	output conversion_start_bit_pkg::conversion_start_bit_state_t conv_state
);
	import conversion_start_bit_pkg::*;

	// ==========================================================
	// Declarations
	conversion_start_bit_state_t state_reg;
	conversion_start_bit_state_t state_next;
	logic [2:0]  pre_reg;
	logic [2:0]  cnt_reg;
	logic [2:0]  cnt_next;
	logic [3:0]  bitp_reg;
	logic [3:0]  bitp_next;
	logic [9:0]  sar_reg;
	logic [9:0]  sar_next;
	logic [9:0]  sar_final;
	logic [9:0]  res_reg;
	logic [2:0]  chan_reg;
	logic        ext_en_reg;
	logic        fast_reg;
	logic        idle_activity_select_reg;
	logic        fast_lat_reg;
	logic        cmd_reg;
	logic        status_reg;
	logic        done_reg;
	logic        idle_q_reg;
	logic        pd_q_reg;
	logic [1:0]  pin_sync_reg;
	logic        pin_prev_reg;
	logic [1:0]  cmp_sync_reg;
	logic [7:0]  p5_s1_reg;
	logic [7:0]  p5_s2_reg;
	logic        tick;
	logic        pwr_ok;
	logic        abort;
	logic        finish;
	logic        ext_edge;
	logic        sw_start;
	logic        start_req;
	logic        setup;
	logic        wr_access;
	logic        wr_ctrl;
	logic        wr_aux;
	logic        mapped;
	logic [2:0]  samp_last;
	logic [2:0]  bit_last;
	logic [3:0]  bitp_last;
	logic [5:0]  len_reg;

	// ==========================================================
	// Machine-cycle prescaler
	assign tick = (pre_reg == `CONVERSION_START_BIT_PRE_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg <= `CONVERSION_START_BIT_RST_PRE;
		end else if (tick) begin
			pre_reg <= `CONVERSION_START_BIT_RST_PRE;
		end else begin
			pre_reg <= pre_reg + 3'h1;
		end
	end

	// ==========================================================
	// Input synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync_reg <= 2'h0;
			cmp_sync_reg <= 2'h0;
			p5_s1_reg    <= 8'h00;
			p5_s2_reg    <= 8'h00;
		end else begin
			pin_sync_reg <= {pin_sync_reg[0], external_start_pin};
			cmp_sync_reg <= {cmp_sync_reg[0], cmp_above};
			p5_s1_reg    <= port5_pins;
			p5_s2_reg    <= p5_s1_reg;
		end
	end

	// Pin level is sampled once per machine cycle, at its end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_reg <= 1'b0;
		end else if (tick) begin
			pin_prev_reg <= pin_sync_reg[1];
		end
	end

	assign ext_edge = tick & pin_sync_reg[1] & ~pin_prev_reg & ext_en_reg;

	// ==========================================================
	// Power state
	assign pwr_ok = ~power_down & ~(idle_mode & ~idle_activity_select_reg);
	assign abort  = (idle_mode & ~idle_q_reg) | (power_down & ~pd_q_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q_reg      <= 1'b0;
			pd_q_reg        <= 1'b0;
			converter_power <= 1'b0;
		end else begin
			idle_q_reg      <= idle_mode;
			pd_q_reg        <= power_down;
			converter_power <= pwr_ok;
		end
	end

	// ==========================================================
	// APB decode
	assign pready    = 1'b1;
	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign wr_ctrl   = wr_access & (paddr == `CONVERSION_START_BIT_OFF_CTRL);
	assign wr_aux    = wr_access & (paddr == `CONVERSION_START_BIT_OFF_AUX);
	assign mapped    = (paddr == `CONVERSION_START_BIT_OFF_CTRL) | (paddr == `CONVERSION_START_BIT_OFF_RESH) |
	                   (paddr == `CONVERSION_START_BIT_OFF_AUX)  | (paddr == `CONVERSION_START_BIT_OFF_PINS);

	// Read data and error are prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= ~mapped;
			prdata  <= 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					`CONVERSION_START_BIT_OFF_CTRL: prdata[7:0] <= {res_reg[1:0], ext_en_reg, done_reg,
					                                 status_reg, chan_reg};
					`CONVERSION_START_BIT_OFF_RESH: prdata[7:0] <= res_reg[9:2];
					`CONVERSION_START_BIT_OFF_AUX:  prdata[7:0] <= {fast_reg, idle_activity_select_reg, 6'h00};
					`CONVERSION_START_BIT_OFF_PINS: prdata[7:0] <= p5_s2_reg;
					default:        prdata[7:0] <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// Software-written control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_reg   <= `CONVERSION_START_BIT_RST_CHAN;
			ext_en_reg <= 1'b0;
		end else if (wr_ctrl) begin
			chan_reg   <= pwdata[`CONVERSION_START_BIT_CTRL_CHAN];
			ext_en_reg <= pwdata[`CONVERSION_START_BIT_CTRL_EXT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_reg <= 1'b0;
			idle_activity_select_reg <= 1'b0;
		end else if (wr_aux) begin
			fast_reg <= pwdata[`CONVERSION_START_BIT_AUX_FAST];
			idle_activity_select_reg <= pwdata[`CONVERSION_START_BIT_AUX_IDLE];
		end
	end

	assign channel_select = chan_reg;

	// ==========================================================
	// Start command flip-flop
	assign sw_start  = wr_ctrl & pwdata[`CONVERSION_START_BIT_CTRL_START];
	assign start_req = (sw_start | ext_edge) & (state_reg == CONVERSION_START_BIT_IDLE) & ~cmd_reg & pwr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= 1'b0;
		end else if (abort) begin
			cmd_reg <= 1'b0;
		end else if (start_req) begin
			cmd_reg <= 1'b1;
		end else if (tick & (state_reg == CONVERSION_START_BIT_IDLE)) begin
			cmd_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Sequencer
	assign samp_last = fast_lat_reg ? `CONVERSION_START_BIT_FSAMP_LAST : `CONVERSION_START_BIT_SAMP_LAST;
	assign bit_last  = fast_lat_reg ? `CONVERSION_START_BIT_FBIT_LAST : `CONVERSION_START_BIT_BIT_LAST;
	assign bitp_last = fast_lat_reg ? `CONVERSION_START_BIT_BITP_LSB8 : `CONVERSION_START_BIT_BITP_LSB10;

	always_comb begin
		sar_final = sar_reg;
		if (!cmp_sync_reg[1]) begin
			sar_final[bitp_reg] = 1'b0;
		end
	end

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		bitp_next  = bitp_reg;
		sar_next   = sar_reg;
		finish     = 1'b0;
		case (state_reg)
			CONVERSION_START_BIT_IDLE: begin
				if (tick & cmd_reg) begin
					state_next = CONVERSION_START_BIT_INIT;
					cnt_next   = 3'h0;
				end
			end
			CONVERSION_START_BIT_INIT: begin
				if (tick) begin
					if (cnt_reg == `CONVERSION_START_BIT_INIT_LAST) begin
						state_next = CONVERSION_START_BIT_SAMPLE;
						cnt_next   = 3'h0;
					end else begin
						cnt_next = cnt_reg + 3'h1;
					end
				end
			end
			CONVERSION_START_BIT_SAMPLE: begin
				if (tick) begin
					if (cnt_reg == samp_last) begin
						state_next = CONVERSION_START_BIT_CONV;
						cnt_next   = 3'h0;
						bitp_next  = `CONVERSION_START_BIT_BITP_MSB;
						sar_next   = `CONVERSION_START_BIT_SAR_MSB;
					end else begin
						cnt_next = cnt_reg + 3'h1;
					end
				end
			end
			CONVERSION_START_BIT_CONV: begin
				if (tick) begin
					if (cnt_reg == bit_last) begin
						cnt_next = 3'h0;
						sar_next = sar_final;
						if (bitp_reg == bitp_last) begin
							state_next = CONVERSION_START_BIT_IDLE;
							finish     = 1'b1;
						end else begin
							bitp_next           = bitp_reg - 4'h1;
							sar_next[bitp_next] = 1'b1;
						end
					end else begin
						cnt_next = cnt_reg + 3'h1;
					end
				end
			end
			default: begin
				state_next = CONVERSION_START_BIT_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= CONVERSION_START_BIT_IDLE;
			cnt_reg   <= 3'h0;
			bitp_reg  <= `CONVERSION_START_BIT_BITP_MSB;
			sar_reg   <= `CONVERSION_START_BIT_RST_RES;
		end else if (abort) begin
			state_reg <= CONVERSION_START_BIT_IDLE;
			cnt_reg   <= 3'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			bitp_reg  <= bitp_next;
			sar_reg   <= sar_next;
		end
	end

	// Mode is frozen for the whole conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_lat_reg <= 1'b0;
		end else if (tick & cmd_reg & (state_reg == CONVERSION_START_BIT_IDLE)) begin
			fast_lat_reg <= fast_reg;
		end
	end

	assign internal_dac_voltage = sar_reg;
	assign sample_en            = (state_reg == CONVERSION_START_BIT_SAMPLE);
	assign conv_state           = state_reg;

	// ==========================================================
	// Status, done flag and result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 1'b0;
		end else if (abort | finish) begin
			status_reg <= 1'b0;
		end else if (tick & (state_reg == CONVERSION_START_BIT_INIT) & (cnt_reg == 3'h0)) begin
			status_reg <= 1'b1;
		end
	end

	// Completion wins over a clearing write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
		end else if (finish & ~abort) begin
			done_reg <= 1'b1;
		end else if (wr_ctrl & ~pwdata[`CONVERSION_START_BIT_CTRL_DONE]) begin
			done_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_reg <= `CONVERSION_START_BIT_RST_RES;
		end else if (finish & ~abort & ~done_reg) begin
			res_reg <= sar_final;
		end
	end

	// ==========================================================
	// Checks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_reg <= 6'h00;
		end else if (tick & (state_reg == CONVERSION_START_BIT_IDLE)) begin
			len_reg <= 6'h00;
		end else if (tick) begin
			len_reg <= len_reg + 6'h01;
		end
	end

	a_len_ten: assert property (@(posedge pclk) disable iff (!presetn)
		finish & ~fast_lat_reg |-> len_reg == `CONVERSION_START_BIT_MC_10 - 6'h01)
		else $error("ten-bit conversion length wrong");

	a_len_fast: assert property (@(posedge pclk) disable iff (!presetn)
		finish & fast_lat_reg |-> len_reg == `CONVERSION_START_BIT_MC_8 - 6'h01)
		else $error("fast conversion length wrong");

	a_mc_period: assert property (@(posedge pclk) disable iff (!presetn)
		tick |=> (!tick) [*5] ##1 tick)
		else $error("machine cycle is not six clocks");

	a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
		tick & state_reg == CONVERSION_START_BIT_IDLE & cmd_reg & ~abort |=> !status_reg ##6 status_reg)
		else $error("status flag not set after first cycle");

	a_done_result: assert property (@(posedge pclk) disable iff (!presetn)
		finish & ~abort & ~done_reg |=> done_reg && res_reg == $past(sar_final) && !status_reg)
		else $error("result or flag not placed at end");

	a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		done_reg |=> res_reg == $past(res_reg))
		else $error("result changed while done flag set");

	a_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg != CONVERSION_START_BIT_IDLE |-> !cmd_reg)
		else $error("start taken during conversion");

	a_abort_idle: assert property (@(posedge pclk) disable iff (!presetn)
		abort |=> state_reg == CONVERSION_START_BIT_IDLE && !status_reg && !cmd_reg)
		else $error("conversion not aborted");

	a_sw_only: assert property (@(posedge pclk) disable iff (!presetn)
		!ext_en_reg & !sw_start & state_reg == CONVERSION_START_BIT_IDLE & !cmd_reg |=> !cmd_reg)
		else $error("start without software request");

	a_sar_first: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == CONVERSION_START_BIT_SAMPLE ##1 state_reg == CONVERSION_START_BIT_CONV |-> sar_reg == `CONVERSION_START_BIT_SAR_MSB)
		else $error("approximation did not start at MSB");

	a_power_off: assert property (@(posedge pclk) disable iff (!presetn)
		idle_mode & ~idle_activity_select_reg |=> !converter_power)
		else $error("converter powered in idle");

	a_ext_start: assert property (@(posedge pclk) disable iff (!presetn)
		ext_edge & state_reg == CONVERSION_START_BIT_IDLE & ~cmd_reg & pwr_ok & ~abort |=> cmd_reg ##6 state_reg == CONVERSION_START_BIT_INIT)
		else $error("external edge did not start conversion");

endmodule // conversion_start_bit_seq

//--- conversion_start_bit_front.sv
// Behavioural model of the analog port, its comparator and the start source.
// Assumes the bench sets vin, vin_chan and digital, and calls pulse_start.
`timescale 1ns/10ps

module conversion_start_bit_front (
	// Clock
	input  logic       pclk,
	// Converter side
	input  logic [2:0] channel_select,
	input  logic [9:0] internal_dac_voltage,
	output logic       cmp_above,
	// Pins
	output logic       external_start_pin,
	output logic [7:0] port5_pins
);
	logic [9:0] vin      = 10'h000;
	logic [2:0] vin_chan = 3'h0;
	logic [7:0] digital  = 8'h00;

	// ==========================================================
	// Comparator: channels other than the driven one sit at ground
	assign cmp_above  = (channel_select == vin_chan) && (vin > internal_dac_voltage);
	assign port5_pins = digital;

	// ==========================================================
	// Start source: rests low, then high for two machine cycles
	initial external_start_pin = 1'b0;

	task automatic pulse_start();
		@(posedge pclk);
		external_start_pin <= 1'b1;
		repeat (12) @(posedge pclk);
		external_start_pin <= 1'b0;
		repeat (12) @(posedge pclk);
	endtask
endmodule // conversion_start_bit_front

//--- testbench.sv
// Self-checking bench for the converter sequencer.
// Assumes the sequencer, its package and the front-end model are compiled first.
`timescale 1ns/10ps
`include "conversion_start_bit_cfg.svh"

module testbench;
	import conversion_start_bit_pkg::*;

	typedef struct {
		logic       fast;
		logic [2:0] chan;
		logic [9:0] vin;
	} conversion_start_bit_row_t;

	logic        pclk, presetn, psel, penable, pwrite, idle_mode, power_down;
	logic [7:0]  paddr, port5_pins;
	logic [31:0] pwdata, prdata, rdq;
	logic        pready, pslverr, rde, external_start_pin, cmp_above, sample_en, converter_power;
	logic [9:0]  internal_dac_voltage, r;
	logic [2:0]  channel_select;
	conversion_start_bit_state_t conv_state;
	int          err_count = 0;
	int          cmp_count = 0;
	int          busy_cnt  = 0;
	int          samp_cnt  = 0;
	int          b0, s0;
	conversion_start_bit_row_t   rows [5] = '{'{1'b0, 3'h3, 10'h2a7}, '{1'b0, 3'h6, 10'h001}, '{1'b0, 3'h0, 10'h3ff},
		'{1'b1, 3'h5, 10'h156}, '{1'b1, 3'h2, 10'h000}};

	conversion_start_bit_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.idle_mode(idle_mode), .power_down(power_down), .external_start_pin(external_start_pin),
		.port5_pins(port5_pins), .cmp_above(cmp_above), .internal_dac_voltage(internal_dac_voltage),
		.channel_select(channel_select), .sample_en(sample_en), .converter_power(converter_power),
		.conv_state(conv_state));

	conversion_start_bit_front front_u (.pclk(pclk), .channel_select(channel_select),
		.internal_dac_voltage(internal_dac_voltage), .cmp_above(cmp_above),
		.external_start_pin(external_start_pin), .port5_pins(port5_pins));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ==========================================================
	// Busy and sampling cycle counts
	always @(posedge pclk) begin
		if (conv_state !== CONVERSION_START_BIT_IDLE) begin
			busy_cnt <= busy_cnt + 1;
		end
		if (sample_en === 1'b1) begin
			samp_cnt <= samp_cnt + 1;
		end
	end

	initial begin
		repeat (100000) @(posedge pclk);
		err_count++;
		summarize();
	end

	// ==========================================================
	// Helpers
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			summarize();
		end else begin
			rdq = prdata;
			rde = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic mark();
		b0 = busy_cnt;
		s0 = samp_cnt;
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		idle_mode  = 1'b0;
		power_down = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		check("power", 32'h1, converter_power);
		rd(`CONVERSION_START_BIT_OFF_CTRL);
		check("ctrl rst", 32'h0, rdq);
		rd(`CONVERSION_START_BIT_OFF_AUX);
		check("aux rst", 32'h0, rdq);
		rd(8'h10);
		check("unmapped err", 32'h1, rde);

		// Ordinary conversions
		foreach (rows[i]) begin
			front_u.vin      = rows[i].vin;
			front_u.vin_chan = rows[i].chan;
			r = (rows[i].vin == 10'h000) ? 10'h000 : rows[i].vin - 10'h001;
			if (rows[i].fast) begin
				r[1:0] = 2'b00;
			end
			wr(`CONVERSION_START_BIT_OFF_AUX, {24'h0, rows[i].fast, 7'h0});
			mark();
			wr(`CONVERSION_START_BIT_OFF_CTRL, {29'h1, rows[i].chan});
			repeat (100) @(posedge pclk);
			rd(`CONVERSION_START_BIT_OFF_CTRL);
			check("status busy", 32'h1, rdq[3]);
			check("channel", rows[i].chan, channel_select);
			repeat (220) @(posedge pclk);
			check("busy clocks", rows[i].fast ? 144 : 300, busy_cnt - b0);
			check("sample clocks", rows[i].fast ? 36 : 48, samp_cnt - s0);
			rd(`CONVERSION_START_BIT_OFF_RESH);
			check("result high", r[9:2], rdq);
			rd(`CONVERSION_START_BIT_OFF_CTRL);
			check("ctrl done", {r[1:0], 3'b010, rows[i].chan}, rdq);
			wr(`CONVERSION_START_BIT_OFF_CTRL, {29'h0, rows[i].chan});
			rd(`CONVERSION_START_BIT_OFF_CTRL);
			check("done cleared", 32'h0, rdq[4]);
		end
		wr(`CONVERSION_START_BIT_OFF_AUX, 32'h0);

		// Pin edge ignored while external start is off
		front_u.vin      = 10'h200;
		front_u.vin_chan = 3'h0;
		mark();
		front_u.pulse_start();
		repeat (12) @(posedge pclk);
		check("no ext start", 32'h0, busy_cnt - b0);

		// Pin edge starts; later starts ignored while busy
		wr(`CONVERSION_START_BIT_OFF_CTRL, 32'h20);
		mark();
		front_u.pulse_start();
		wr(`CONVERSION_START_BIT_OFF_CTRL, 32'h28);
		front_u.pulse_start();
		repeat (280) @(posedge pclk);
		check("one conversion", 32'd300, busy_cnt - b0);
		rd(`CONVERSION_START_BIT_OFF_RESH);
		check("ext result", 32'h7f, rdq);

		// Flagged result survives a new conversion and idle entry
		front_u.vin = 10'h010;
		mark();
		wr(`CONVERSION_START_BIT_OFF_CTRL, 32'h38);
		repeat (320) @(posedge pclk);
		check("second run", 32'd300, busy_cnt - b0);
		idle_mode <= 1'b1;
		repeat (3) @(negedge pclk);
		check("idle power off", 32'h0, converter_power);
		rd(`CONVERSION_START_BIT_OFF_RESH);
		check("held result", 32'h7f, rdq);
		rd(`CONVERSION_START_BIT_OFF_CTRL);
		check("held ctrl", 32'hf0, rdq);
		idle_mode <= 1'b0;
		wr(`CONVERSION_START_BIT_OFF_CTRL, 32'h0);

		// Idle and power-down abort a running conversion
		for (int k = 0; k < 2; k++) begin
			wr(`CONVERSION_START_BIT_OFF_CTRL, 32'h08);
			repeat (100) @(posedge pclk);
			idle_mode  <= (k == 0);
			power_down <= (k == 1);
			repeat (3) @(negedge pclk);
			check("aborted", CONVERSION_START_BIT_IDLE, conv_state);
			rd(`CONVERSION_START_BIT_OFF_CTRL);
			check("no flags", 32'h0, rdq[4:3]);
			idle_mode  <= 1'b0;
			power_down <= 1'b0;
			repeat (6) @(posedge pclk);
		end

		// Converter stays powered in idle when asked
		wr(`CONVERSION_START_BIT_OFF_AUX, 32'h40);
		idle_mode <= 1'b1;
		mark();
		wr(`CONVERSION_START_BIT_OFF_CTRL, 32'h08);
		repeat (320) @(posedge pclk);
		check("idle power on", 32'h1, converter_power);
		check("idle conversion", 32'd300, busy_cnt - b0);
		idle_mode <= 1'b0;

		// Analog port read back as digital input, not writable
		front_u.digital = 8'ha5;
		wr(`CONVERSION_START_BIT_OFF_PINS, 32'hff);
		rd(`CONVERSION_START_BIT_OFF_PINS);
		check("port readback", 32'ha5, rdq);

		// Reset in mid-conversion returns everything to rest
		wr(`CONVERSION_START_BIT_OFF_CTRL, 32'h0b);
		repeat (60) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		check("reset state", CONVERSION_START_BIT_IDLE, conv_state);
		check("reset power", 32'h1, converter_power);
		rd(`CONVERSION_START_BIT_OFF_CTRL);
		check("reset ctrl", 32'h0, rdq);
		summarize();
	end
endmodule // testbench
